// File: pkg/bacalu_pkg.sv
// Types and constants of the binary accumulator ALU
package bacalu_pkg;
    // ==============================================
    // Widths
    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int MEM_AW = 16;

    // ==============================================
    // Register map and reset values
    localparam logic [31:0] ACC_OFS = 32'h0000_0000;
    localparam logic [31:0] FLAGS_OFS = 32'h0000_0004;
    localparam logic [31:0] STATUS_OFS = 32'h0000_0008;
    localparam int STATUS_BUSY_BIT = 0;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [MEM_AW-1:0] MEM_ADDR_RST = 16'h0000;

    // ==============================================
    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ==============================================
    // Instruction types
    typedef enum logic [1:0] {
        OP_ADD_D,
        OP_SUB_W,
        OP_SUB_D,
        OP_MUL_W
    } bacalu_op_t;

    typedef enum logic [1:0] {
        SRC_IMM,
        SRC_DIRECT,
        SRC_POINTER
    } bacalu_src_t;

    typedef struct packed {
        logic sign_overflow_flag;
        logic negative_result_flag;
        logic full_width_borrow_flag;
        logic low_half_borrow_flag;
        logic full_width_carry_flag;
        logic low_half_carry_flag;
        logic zero_result_flag;
    } bacalu_flags_t;

    localparam bacalu_flags_t FLAGS_RST = 7'h00;

    typedef struct packed {
        bacalu_op_t op;
        bacalu_src_t src;
        logic [ACC_W-1:0] arg;
    } bacalu_instr_t;

    typedef struct packed {
        logic rd;
        logic [MEM_AW-1:0] addr;
    } bacalu_memreq_t;

    typedef struct packed {
        logic en;
        logic [ACC_W-1:0] data;
    } bacalu_accwr_t;
endpackage

// File: src/bacalu_ahb_slave.sv
// AHB-Lite register slave of the binary accumulator ALU
`timescale 1ns/10ps
module bacalu_ahb_slave (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // AHB-Lite
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Core side
    input wire logic [31:0] acc_in,
    input wire bacalu_pkg::bacalu_flags_t flags_in,
    input wire logic busy_in,
    output bacalu_pkg::bacalu_accwr_t acc_wr_out
);
    // ==============================================
    // State
    typedef struct packed {
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
        logic hreadyout;
        logic hresp;
    } bacalu_ahb_state_t;

    bacalu_ahb_state_t s;
    bacalu_ahb_state_t next_s;
    logic addr_ph;

    function automatic logic [31:0] read_mux(input logic [31:0] a, input logic [31:0] acc,
                                             input bacalu_pkg::bacalu_flags_t f,
                                             input logic busy);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == bacalu_pkg::ACC_OFS) begin
            r = acc;
        end else if (a == bacalu_pkg::FLAGS_OFS) begin
            r = {25'h0000000, f};
        end else if (a == bacalu_pkg::STATUS_OFS) begin
            r[bacalu_pkg::STATUS_BUSY_BIT] = busy;
        end
        return r;
    endfunction

    // ==============================================
    // Write strobe toward the core
    // Writes while an instruction runs are dropped, not queued
    assign acc_wr_out = '{en: s.wr_pend && (s.wr_addr == bacalu_pkg::ACC_OFS) && !busy_in,
                          data: hwdata_in};
    assign addr_ph = hsel_in && hready_in && htrans_in[1];

    always_comb begin
        next_s = s;
        next_s.hreadyout = 1'b1;
        next_s.hresp = bacalu_pkg::HRESP_OKAY;
        next_s.wr_pend = addr_ph && hwrite_in && (hsize_in == bacalu_pkg::HSIZE_WORD);
        next_s.wr_addr = haddr_in;
        if (addr_ph && !hwrite_in) begin
            // Bypass so a read right after a write sees the new value
            if (acc_wr_out.en && haddr_in == bacalu_pkg::ACC_OFS) begin
                next_s.rdata = hwdata_in;
            end else begin
                next_s.rdata = read_mux(haddr_in, acc_in, flags_in, busy_in);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s <= '{wr_pend: 1'b0, wr_addr: 32'h0000_0000, rdata: 32'h0000_0000,
                   hreadyout: 1'b1, hresp: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign hrdata_out = s.rdata;
    assign hreadyout_out = s.hreadyout;
    assign hresp_out = s.hresp;
endmodule

// File: src/bacalu_core.sv
// Binary accumulator ALU: sequencer port, memory fetch, arithmetic, flags
`timescale 1ns/10ps
module bacalu_core (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Instruction sequencer
    input wire logic instr_valid_in,
    input wire bacalu_pkg::bacalu_instr_t instr_in,
    output logic instr_ready_out,
    output logic done_out,
    // Data memory
    output bacalu_pkg::bacalu_memreq_t mem_req_out,
    input wire logic mem_rvalid_in,
    input wire logic [15:0] mem_rdata_in,
    // Result
    output logic [31:0] acc_out,
    output bacalu_pkg::bacalu_flags_t flags_out,
    // AHB-Lite
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);
    // ==============================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PTR,
        ST_LO,
        ST_HI,
        ST_EXEC
    } bacalu_core_st_t;

    typedef struct packed {
        bacalu_core_st_t st;
        bacalu_pkg::bacalu_op_t op;
        logic [31:0] opnd;
        logic [31:0] acc_pre;
        logic [31:0] acc;
        bacalu_pkg::bacalu_flags_t flags;
        bacalu_pkg::bacalu_memreq_t mem;
        logic done;
        logic ready;
    } bacalu_core_state_t;

    bacalu_core_state_t s;
    bacalu_core_state_t next_s;
    bacalu_pkg::bacalu_accwr_t acc_wr;
    logic [32:0] sum33;
    logic [16:0] sum17;
    logic [32:0] diff33;
    logic [16:0] diff17;
    logic [47:0] prod48;

    function automatic logic is_double(input bacalu_pkg::bacalu_op_t op);
        return (op == bacalu_pkg::OP_ADD_D) || (op == bacalu_pkg::OP_SUB_D);
    endfunction

    // ==============================================
    // Register slave
    bacalu_ahb_slave u_ahb (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hsize_in(hsize_in),
        .hwdata_in(hwdata_in),
        .hready_in(hready_in),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out),
        .acc_in(s.acc),
        .flags_in(s.flags),
        .busy_in(s.st != ST_IDLE),
        .acc_wr_out(acc_wr)
    );

    // ==============================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.mem.rd = 1'b0;
        next_s.done = 1'b0;
        // Plain binary, no decimal adjust anywhere
        sum33 = {1'b0, s.acc} + {1'b0, s.opnd};
        sum17 = {1'b0, s.acc[15:0]} + {1'b0, s.opnd[15:0]};
        diff33 = {1'b0, s.acc} - {1'b0, s.opnd};
        diff17 = {1'b0, s.acc[15:0]} - {1'b0, s.opnd[15:0]};
        prod48 = s.acc * s.opnd[15:0];
        case (s.st)
            ST_IDLE: begin
                // Bus write lands before an instruction taken this cycle
                if (acc_wr.en) begin
                    next_s.acc = acc_wr.data;
                end
                if (instr_valid_in) begin
                    next_s.op = instr_in.op;
                    next_s.ready = 1'b0;
                    next_s.mem.addr = instr_in.arg[15:0];
                    case (instr_in.src)
                        bacalu_pkg::SRC_IMM: begin
                            if (is_double(instr_in.op)) begin
                                next_s.opnd = instr_in.arg;
                            end else begin
                                next_s.opnd = {16'h0000, instr_in.arg[15:0]};
                            end
                            next_s.st = ST_EXEC;
                        end
                        bacalu_pkg::SRC_POINTER: begin
                            next_s.mem.rd = 1'b1;
                            next_s.st = ST_PTR;
                        end
                        default: begin
                            next_s.mem.rd = 1'b1;
                            next_s.st = ST_LO;
                        end
                    endcase
                end
            end
            ST_PTR: begin
                if (mem_rvalid_in) begin
                    next_s.mem.rd = 1'b1;
                    next_s.mem.addr = mem_rdata_in;
                    next_s.st = ST_LO;
                end
            end
            ST_LO: begin
                if (mem_rvalid_in) begin
                    // Word operands zero-extend
                    next_s.opnd = {16'h0000, mem_rdata_in};
                    if (is_double(s.op)) begin
                        // Low word first, high word at the next address
                        next_s.mem.rd = 1'b1;
                        next_s.mem.addr = s.mem.addr + 16'h0001;
                        next_s.st = ST_HI;
                    end else begin
                        next_s.st = ST_EXEC;
                    end
                end
            end
            ST_HI: begin
                if (mem_rvalid_in) begin
                    next_s.opnd[31:16] = mem_rdata_in;
                    next_s.st = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_s.acc_pre = s.acc;
                case (s.op)
                    bacalu_pkg::OP_ADD_D: begin
                        next_s.acc = sum33[31:0];
                        next_s.flags.low_half_carry_flag = sum17[16];
                        next_s.flags.full_width_carry_flag = sum33[32];
                        next_s.flags.sign_overflow_flag = (s.acc[31] == s.opnd[31])
                            && (sum33[31] != s.acc[31]);
                    end
                    bacalu_pkg::OP_SUB_W, bacalu_pkg::OP_SUB_D: begin
                        next_s.acc = diff33[31:0];
                        next_s.flags.low_half_borrow_flag = diff17[16];
                        next_s.flags.full_width_borrow_flag = diff33[32];
                    end
                    default: begin
                        // Upper product bits fall away
                        next_s.acc = prod48[31:0];
                    end
                endcase
                // Other flags keep their last value
                next_s.flags.zero_result_flag = (next_s.acc == 32'h0000_0000);
                next_s.flags.negative_result_flag = next_s.acc[31];
                next_s.done = 1'b1;
                next_s.ready = 1'b1;
                next_s.st = ST_IDLE;
            end
            default: begin
                next_s.st = ST_IDLE;
                next_s.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s <= '{st: ST_IDLE, op: bacalu_pkg::OP_ADD_D, opnd: 32'h0000_0000,
                   acc_pre: 32'h0000_0000, acc: bacalu_pkg::ACC_RST,
                   flags: bacalu_pkg::FLAGS_RST,
                   mem: '{rd: 1'b0, addr: bacalu_pkg::MEM_ADDR_RST},
                   done: 1'b0, ready: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // ==============================================
    // Outputs
    assign instr_ready_out = s.ready;
    assign done_out = s.done;
    assign mem_req_out = s.mem;
    assign acc_out = s.acc;
    assign flags_out = s.flags;

    // ==============================================
    // Checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    property p_add_sum;
        done_out && s.op == bacalu_pkg::OP_ADD_D |-> acc_out == s.acc_pre + s.opnd;
    endproperty
    a_add_sum: assert property (p_add_sum)
        else $error("double add result wrong");

    property p_dbl_fetch;
        s.st == ST_LO && mem_rvalid_in && is_double(s.op)
            |=> mem_req_out.rd && mem_req_out.addr == $past(mem_req_out.addr) + 16'h0001;
    endproperty
    a_dbl_fetch: assert property (p_dbl_fetch)
        else $error("high word not fetched at next address");

    property p_zero;
        done_out |-> flags_out.zero_result_flag == (acc_out == 32'h0000_0000);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag mismatch");

    property p_low_carry;
        done_out && s.op == bacalu_pkg::OP_ADD_D
            |-> flags_out.low_half_carry_flag == (s.acc_pre[15:0] > ~s.opnd[15:0]);
    endproperty
    a_low_carry: assert property (p_low_carry)
        else $error("low half carry wrong");

    property p_full_carry;
        done_out && s.op == bacalu_pkg::OP_ADD_D
            |-> flags_out.full_width_carry_flag == (s.acc_pre > ~s.opnd);
    endproperty
    a_full_carry: assert property (p_full_carry)
        else $error("full width carry wrong");

    property p_negative;
        done_out |-> flags_out.negative_result_flag == acc_out[31];
    endproperty
    a_negative: assert property (p_negative)
        else $error("negative flag mismatch");

    property p_overflow;
        done_out && s.op == bacalu_pkg::OP_ADD_D
            |-> flags_out.sign_overflow_flag ==
                ((s.acc_pre[31] == s.opnd[31]) && (acc_out[31] != s.acc_pre[31]));
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("sign overflow flag wrong");

    property p_keep_carry;
        done_out && s.op != bacalu_pkg::OP_ADD_D
            |-> $stable(flags_out.low_half_carry_flag)
                && $stable(flags_out.full_width_carry_flag)
                && $stable(flags_out.sign_overflow_flag);
    endproperty
    a_keep_carry: assert property (p_keep_carry)
        else $error("carry flags changed by non-add");

    property p_word_opnd;
        s.st == ST_EXEC && !is_double(s.op) |-> s.opnd[31:16] == 16'h0000;
    endproperty
    a_word_opnd: assert property (p_word_opnd)
        else $error("word operand not zero extended");

    property p_sub_diff;
        done_out && (s.op == bacalu_pkg::OP_SUB_W || s.op == bacalu_pkg::OP_SUB_D)
            |-> acc_out == s.acc_pre - s.opnd
                && flags_out.low_half_borrow_flag == (s.acc_pre[15:0] < s.opnd[15:0])
                && flags_out.full_width_borrow_flag == (s.acc_pre < s.opnd);
    endproperty
    a_sub_diff: assert property (p_sub_diff)
        else $error("subtract result or borrow wrong");

    property p_mul;
        done_out && s.op == bacalu_pkg::OP_MUL_W
            |-> acc_out == 32'(s.acc_pre * s.opnd[15:0])
                && $stable(flags_out.low_half_borrow_flag);
    endproperty
    a_mul: assert property (p_mul)
        else $error("multiply result wrong");

    property p_done_pulse;
        s.st == ST_EXEC |=> done_out && instr_ready_out ##1 !done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done not a single pulse after execute");

    property p_busy_no_ready;
        instr_valid_in && instr_ready_out |=> !instr_ready_out && !done_out;
    endproperty
    a_busy_no_ready: assert property (p_busy_no_ready)
        else $error("ready while instruction still running");

    property p_keep_borrow;
        done_out && s.op != bacalu_pkg::OP_SUB_W && s.op != bacalu_pkg::OP_SUB_D
            |-> $stable(flags_out.low_half_borrow_flag)
                && $stable(flags_out.full_width_borrow_flag);
    endproperty
    a_keep_borrow: assert property (p_keep_borrow)
        else $error("borrow flags changed by non-subtract");

    property p_ptr_fetch;
        s.st == ST_PTR && mem_rvalid_in
            |=> mem_req_out.rd && mem_req_out.addr == $past(mem_rdata_in);
    endproperty
    a_ptr_fetch: assert property (p_ptr_fetch)
        else $error("pointer not followed to operand address");

    // A bus write while busy is dropped, so the accumulator must not move during the operand fetch
    property p_busy_acc_hold;
        s.st == ST_PTR || s.st == ST_LO || s.st == ST_HI |=> acc_out == $past(acc_out);
    endproperty
    a_busy_acc_hold: assert property (p_busy_acc_hold)
        else $error("accumulator changed while an instruction ran");
endmodule

// File: verif/bacalu_mem_model.sv
// Word-addressed data memory model on the far side of the core
`timescale 1ns/10ps
module bacalu_mem_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Request side
    input wire bacalu_pkg::bacalu_memreq_t mem_req_in,
    input wire logic [2:0] delay_in,
    // Answer side
    output logic mem_rvalid_out,
    output logic [15:0] mem_rdata_out
);
    // ==============================================
    // Storage and read timing
    logic [15:0] mem [0:65535];
    logic pending;
    logic [2:0] wait_cnt;
    logic [15:0] addr;

    // Data toggles outside the answer cycle, so a stale read never matches
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pending <= 1'b0;
            wait_cnt <= 3'h0;
            addr <= 16'h0000;
            mem_rvalid_out <= 1'b0;
            mem_rdata_out <= 16'h0000;
        end else begin
            mem_rvalid_out <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
            if (mem_req_in.rd) begin
                addr <= mem_req_in.addr;
                if (delay_in == 3'h0) begin
                    mem_rvalid_out <= 1'b1;
                    mem_rdata_out <= mem[mem_req_in.addr];
                end else begin
                    pending <= 1'b1;
                    wait_cnt <= delay_in - 3'h1;
                end
            end else if (pending) begin
                if (wait_cnt == 3'h0) begin
                    pending <= 1'b0;
                    mem_rvalid_out <= 1'b1;
                    mem_rdata_out <= mem[addr];
                end else begin
                    wait_cnt <= wait_cnt - 3'h1;
                end
            end
        end
    end
endmodule

// File: verif/binary_accumulator_alu_bench.sv
// Self-checking bench of the binary accumulator ALU core
`timescale 1ns/10ps
module binary_accumulator_alu_bench;
    // ==============================================
    // Signals
    logic clk, rst_n, instr_valid, mem_rvalid, hsel, hwrite, hreadyout, hresp;
    logic instr_ready, done;
    logic [1:0] htrans;
    logic [2:0] hsize, mem_delay;
    logic [15:0] mem_rdata;
    logic [31:0] haddr, hwdata, hrdata, acc, m_acc, rd;
    logic [6:0] m_flags;
    logic [15:0] ref_mem [0:63];
    bacalu_pkg::bacalu_instr_t instr;
    bacalu_pkg::bacalu_memreq_t mem_req;
    bacalu_pkg::bacalu_flags_t flags;
    int fails, check_count, cycles, seed, i;
    logic [1:0] r_op, r_src;
    logic [31:0] r_arg;
    // Boundary cases: wrap to zero, sign overflow, low carry, borrows, multiply to ffff0000 and by zero
    logic [31:0] b_acc [0:7] = '{32'hffffffff, 32'h7fffffff, 32'h0000ffff, 32'h00000000,
        32'h80000000, 32'h00050005, 32'h00010000, 32'h12345678};
    logic [31:0] b_arg [0:7] = '{32'h00000001, 32'h00000001, 32'h00000001, 32'hffff0001,
        32'h00000001, 32'h00050005, 32'h0000ffff, 32'h00000000};
    logic [1:0] b_op [0:7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

    // ==============================================
    // Design and memory
    bacalu_core i_dut (.core_clk_in(clk), .arst_n_in(rst_n), .instr_valid_in(instr_valid),
        .instr_in(instr), .instr_ready_out(instr_ready), .done_out(done),
        .mem_req_out(mem_req), .mem_rvalid_in(mem_rvalid), .mem_rdata_in(mem_rdata),
        .acc_out(acc), .flags_out(flags), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp));
    bacalu_mem_model i_mem (.core_clk_in(clk), .arst_n_in(rst_n), .mem_req_in(mem_req),
        .delay_in(mem_delay), .mem_rvalid_out(mem_rvalid), .mem_rdata_out(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report;
        end
    end

    // ==============================================
    // Tasks
    task final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task chk_reset;
        @(posedge clk);
        chk("acc", 32'h0, acc);
        chk("flags", 32'h0, {25'h0, flags});
        chk("done", 32'h0, {31'h0, done});
        chk("hrdata", 32'h0, hrdata);
        chk("ready", 32'h1, {31'h0, instr_ready});
    endtask

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= bacalu_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task set_acc(input logic [31:0] v);
        ahb(1'b1, bacalu_pkg::ACC_OFS, v, rd);
        m_acc = v;
    endtask

    // Reference arithmetic on the model's accumulator and flags
    task ref_exec(input logic [1:0] op, input logic [1:0] src, input logic [31:0] arg);
        logic [31:0] opd;
        logic [32:0] r;
        logic [16:0] lo;
        logic [15:0] a;
        a = arg[15:0];
        if (src == 2'h2) a = ref_mem[a[5:0]];
        opd = (src == 2'h0) ? arg : {ref_mem[a[5:0] + 6'h1], ref_mem[a[5:0]]};
        if (op[0]) opd = {16'h0000, opd[15:0]};
        if (op == 2'h0) begin
            r = {1'b0, m_acc} + {1'b0, opd};
            lo = {1'b0, m_acc[15:0]} + {1'b0, opd[15:0]};
            m_flags[1] = lo[16];
            m_flags[2] = r[32];
            m_flags[6] = (m_acc[31] == opd[31]) && (r[31] != m_acc[31]);
        end else if (op == 2'h3) begin
            r = {1'b0, m_acc * opd};
        end else begin
            r = {1'b0, m_acc} - {1'b0, opd};
            m_flags[3] = m_acc[15:0] < opd[15:0];
            m_flags[4] = m_acc < opd;
        end
        m_acc = r[31:0];
        m_flags[0] = (m_acc == 32'h0);
        m_flags[5] = m_acc[31];
    endtask

    task run(input logic [1:0] op, input logic [1:0] src, input logic [31:0] arg);
        instr_valid <= 1'b1;
        instr <= {op, src, arg};
        mem_delay <= 3'($random(seed));
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        ref_exec(op, src, arg);
        do @(posedge clk); while (done !== 1'b1);
        chk("acc", m_acc, acc);
        chk("flags", {25'h0, m_flags}, {25'h0, flags});
        chk("ready", 32'h1, {31'h0, instr_ready});
    endtask

    // ==============================================
    // Main sequence
    initial begin
        seed = 88;
        rst_n = 1'b0;
        {instr_valid, hsel, hwrite, htrans, haddr, hwdata, mem_delay} = '0;
        hsize = bacalu_pkg::HSIZE_WORD;
        instr = '0;
        m_acc = 32'h0;
        m_flags = 7'h00;
        for (i = 0; i < 64; i++) begin
            ref_mem[i] = (i >= 32 && i < 40) ? 16'(i % 16) : 16'($random(seed));
            i_mem.mem[i] = ref_mem[i];
        end
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_reset;
        ahb(1'b0, bacalu_pkg::FLAGS_OFS, 32'h0, rd);
        chk("flags reg", 32'h0, rd);
        ahb(1'b0, 32'h0000_000c, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        $display("test reset finished");
        for (i = 0; i < 8; i++) begin
            set_acc(b_acc[i]);
            run(b_op[i], 2'h0, b_arg[i]);
        end
        // Flags are read only; a write must leave them as they were
        ahb(1'b1, bacalu_pkg::FLAGS_OFS, 32'hffffffff, rd);
        ahb(1'b0, bacalu_pkg::FLAGS_OFS, 32'h0, rd);
        chk("flags reg", {25'h0, m_flags}, rd);
        $display("test boundary finished");
        // Long memory wait: status shows busy and an ACC write is dropped
        instr_valid <= 1'b1;
        instr <= {2'h0, 2'h1, 32'h0000_0004};
        mem_delay <= 3'h7;
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        ref_exec(2'h0, 2'h1, 32'h0000_0004);
        ahb(1'b0, bacalu_pkg::STATUS_OFS, 32'h0, rd);
        chk("status", 32'h1, rd);
        ahb(1'b1, bacalu_pkg::ACC_OFS, 32'h5a5a_5a5a, rd);
        do @(posedge clk); while (done !== 1'b1);
        chk("acc", m_acc, acc);
        chk("flags", {25'h0, m_flags}, {25'h0, flags});
        $display("test busy finished");
        for (i = 0; i < 120; i++) begin
            r_op = 2'($random(seed));
            // Source code 3 decodes as direct
            r_src = 2'(i % 4);
            r_arg = (r_src == 2'h0) ? $random(seed) : r_src[0] ?
                {28'h0, 4'($random(seed))} : {29'h4, 3'($random(seed))};
            if (i % 10 == 0) set_acc($random(seed));
            run(r_op, r_src, r_arg);
        end
        ahb(1'b0, bacalu_pkg::ACC_OFS, 32'h0, rd);
        chk("acc reg", m_acc, rd);
        $display("test random finished");
        // Reset with the core idle brings every output back to its idle value
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        m_acc = 32'h0;
        m_flags = 7'h00;
        chk_reset;
        run(2'h0, 2'h0, 32'h0000_0001);
        $display("test second reset finished");
        final_report;
    end
endmodule
